// [fimvc_pkg.sv]
// constants, carriers and field layout of the fast mask and vector block
// assumes an apb master and a core that takes level requests
// Function
// - clear register drops each written-one enable bit
// - fast status is raw AND fast enable
// - any fast status bit raises fast request
// - no fast encoding unless fast vectoring enabled
// - config bit 2 drives fast bit 1
// - config bit 1 drives normal bit 1
// - programmed interrupts bypass enable masks
// - nesting bit 0 enables normal vectoring
// - nesting bit 1 enables fast vectoring
// - eight nested levels; fast outranks normal when both nesting bits are set
// - per-source priority steers nesting and vector
// - base locates table of 32 pointers
// - vector: base at 22:7, source 6:2
// - fast enable clears normal enable, reverse
// - or of fast bits 31:1 is bit 0
// - three-bit priority; source 0 unprioritised
// - one bit position per source everywhere
package fimvc_pkg;
  localparam logic [31:0] ADDR_BASE   = 32'hffff_0014;
  localparam logic [31:0] ADDR_VEC    = 32'hffff_001c;
  localparam logic [31:0] ADDR_FSTAT  = 32'hffff_0100;
  localparam logic [31:0] ADDR_FRAW   = 32'hffff_0104;
  localparam logic [31:0] ADDR_FEN    = 32'hffff_0108;
  localparam logic [31:0] ADDR_FCLR   = 32'hffff_010c;
  localparam logic [31:0] ADDR_SWI    = 32'hffff_0110;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] SRC_VALID   = 32'h0fff_fffe;
  localparam int          OR_BIT      = 0;
  localparam int          SWI_SRC_BIT = 1;
  localparam int          SWI_IRQ_BIT = 1;
  localparam int          SWI_FIQ_BIT = 2;
  localparam int          NEST_IRQ    = 0;
  localparam int          NEST_FIQ    = 1;
  localparam int          BASE_W      = 16;
  localparam int          VEC_SRC_LSB = 2;
  localparam int          VEC_BAS_LSB = 7;
  localparam int          SRC_W       = 5;
  localparam int          PRIO_W      = 3;
  localparam int          LEVELS      = 8;
  localparam int          SRC_MAX     = 27;
  localparam int          TABLE_LEN   = 32;

  typedef logic [31:0][PRIO_W-1:0] fimvc_prio_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } fimvc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fimvc_apb_rsp_s;

  typedef enum logic [1:0] {
    FIMVC_IDLE = 2'b01,
    FIMVC_ACK  = 2'b10
  } fimvc_apb_e;
endpackage

// [fimvc_prio.sv]
// priority pick over active sources, lowest level value wins
// assumes active and prio are stable combinational inputs
`timescale 1ns/1ps
module fimvc_prio #(
  parameter int NSRC = 28
) (
  input  wire logic [31:0]                         active,
  input  wire fimvc_pkg::fimvc_prio_t              prio,
  output logic                                     found,
  output logic [fimvc_pkg::SRC_W-1:0]              src,
  output logic [fimvc_pkg::PRIO_W-1:0]             lvl
);
  always_comb begin
    found = 1'b0;
    src   = '0;
    lvl   = '0;
    // source 0 carries the fast or and is never picked
    for (int i = 1; i < NSRC; i++) begin
      // strict compare keeps the lowest index on a tie
      if (active[i] && (!found || prio[i] < lvl)) begin
        found = 1'b1;
        src   = fimvc_pkg::SRC_W'(i);
        lvl   = prio[i];
      end
    end
  end
endmodule

// [fimvc_top.sv]
// fast mask, programmed interrupts, vector base and active vector
// assumes apb master, synchronous sources, external normal mask logic
`timescale 1ns/1ps
module fimvc_top #(
  parameter int NSRC = fimvc_pkg::SRC_MAX + 1
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire fimvc_pkg::fimvc_apb_req_s        apb_req,
  output fimvc_pkg::fimvc_apb_rsp_s             apb_rsp_q,
  input  wire logic [31:0]                      fast_raw_src,
  input  wire logic [31:0]                      normal_raw_src,
  input  wire logic [31:0]                      normal_enable_mask,
  input  wire logic [31:0]                      normal_en_set,
  input  wire logic [1:0]                       nesting_control,
  input  wire fimvc_pkg::fimvc_prio_t           prio_fields,
  input  wire logic                             normal_eoi,
  output logic                                  fast_irq_q,
  output logic                                  normal_irq_q,
  output logic [31:0]                           normal_raw_signal_q,
  output logic [31:0]                           normal_masked_status_q,
  output logic [31:0]                           normal_en_clr_q,
  output logic [fimvc_pkg::SRC_W-1:0]           fast_vec_src_q
);
  fimvc_pkg::fimvc_apb_e           st_q;
  fimvc_pkg::fimvc_apb_e           st_d;
  logic [31:0]                     fast_en_q;
  logic [31:0]                     fast_en_d;
  logic [31:0]                     fast_raw_q;
  logic [31:0]                     fast_stat_q;
  logic [fimvc_pkg::BASE_W-1:0]    base_q;
  logic [2:0]                      swi_q;
  logic [fimvc_pkg::SRC_W-1:0]     vec_src_q;
  logic [fimvc_pkg::LEVELS-1:0]    insvc_q;
  logic [fimvc_pkg::LEVELS-1:0]    insvc_d;

  // bus decode
  wire        setup   = apb_req.psel && !apb_req.penable;
  wire        fire    = apb_req.psel && apb_req.penable && apb_rsp_q.pready;
  wire        wr_fire = fire && apb_req.pwrite;
  wire        rd_fire = fire && !apb_req.pwrite;
  wire [31:0] addr    = apb_req.paddr;
  wire [31:0] wdata   = apb_req.pwdata;
  wire        hit_base  = addr == fimvc_pkg::ADDR_BASE;
  wire        hit_vec   = addr == fimvc_pkg::ADDR_VEC;
  wire        hit_fstat = addr == fimvc_pkg::ADDR_FSTAT;
  wire        hit_fraw  = addr == fimvc_pkg::ADDR_FRAW;
  wire        hit_fen   = addr == fimvc_pkg::ADDR_FEN;
  wire        hit_fclr  = addr == fimvc_pkg::ADDR_FCLR;
  wire        hit_swi   = addr == fimvc_pkg::ADDR_SWI;
  wire        hit_any   = hit_base | hit_vec | hit_fstat | hit_fraw
                        | hit_fen | hit_fclr | hit_swi;
  wire        wr_fen  = wr_fire && hit_fen;
  wire        wr_fclr = wr_fire && hit_fclr;
  wire        wr_swi  = wr_fire && hit_swi;
  wire        wr_base = wr_fire && hit_base;
  wire        rd_vec  = rd_fire && hit_vec;

  // enable mask: ones set, clear register and normal side clear
  wire [31:0] fen_set = wr_fen  ? (wdata & fimvc_pkg::SRC_VALID) : '0;
  wire [31:0] fen_clr = wr_fclr ? wdata : '0;
  assign fast_en_d = (fast_en_q | fen_set) & ~fen_clr & ~normal_en_set;

  // status vectors, same bit per source in both types
  wire        nest_irq = nesting_control[fimvc_pkg::NEST_IRQ];
  wire        nest_fiq = nesting_control[fimvc_pkg::NEST_FIQ];
  wire [31:1] fstat_hi = {fast_raw_src[31:2] & fast_en_q[31:2],
                          swi_q[fimvc_pkg::SWI_FIQ_BIT]};
  wire        fiq_or   = |fstat_hi;
  wire [31:0] fstat_d  = {fstat_hi, fiq_or};
  wire [31:0] fraw_d   = {fast_raw_src[31:2], swi_q[fimvc_pkg::SWI_FIQ_BIT], fiq_or};
  wire [31:1] nstat_hi = {normal_raw_src[31:2] & normal_enable_mask[31:2],
                          swi_q[fimvc_pkg::SWI_IRQ_BIT]};
  wire [31:0] nstat_d  = {nstat_hi, fiq_or};
  wire [31:0] nraw_d   = {normal_raw_src[31:2], swi_q[fimvc_pkg::SWI_IRQ_BIT], fiq_or};

  // priority pick for each type
  logic                            n_found;
  logic [fimvc_pkg::SRC_W-1:0]     n_src;
  logic [fimvc_pkg::PRIO_W-1:0]    n_lvl;
  logic                            f_found;
  logic [fimvc_pkg::SRC_W-1:0]     f_src;

  fimvc_prio #(.NSRC(NSRC)) u_npick (
    .active (nstat_d),
    .prio   (prio_fields),
    .found  (n_found),
    .src    (n_src),
    .lvl    (n_lvl)
  );

  fimvc_prio #(.NSRC(NSRC)) u_fpick (
    .active (fstat_d),
    .prio   (prio_fields),
    .found  (f_found),
    .src    (f_src),
    .lvl    ()
  );

  // in-service levels: one bit per level gives eight-deep nesting
  function automatic logic [3:0] lowest_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'(fimvc_pkg::LEVELS);
    for (int i = fimvc_pkg::LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  wire [3:0] cur_lvl  = lowest_set(insvc_q);
  wire       n_beats  = n_found && ({1'b0, n_lvl} < cur_lvl);
  // eoi retires the most recent, i.e. the numerically lowest, level
  wire [7:0] insvc_rt = normal_eoi ? (insvc_q & (insvc_q - 8'h01)) : insvc_q;
  wire [7:0] insvc_nw = (rd_vec && nest_irq && n_found) ? (8'h01 << n_lvl) : 8'h00;
  assign insvc_d = insvc_rt | insvc_nw;

  // fast requests outrank normal ones only when both normal and fast vectoring are on
  wire nirq_d = nest_irq ? (n_beats && !(nest_fiq && fiq_or))
                         : (|nstat_d);

  // read mux, sampled at setup; data stands through the access phase
  wire [31:0] vec_word = {9'h000, base_q, vec_src_q, 2'b00};
  wire [31:0] rd_data  =
      hit_base  ? {16'h0000, base_q} :
      hit_vec   ? vec_word :
      hit_fstat ? fast_stat_q :
      hit_fraw  ? fast_raw_q :
      hit_fen   ? fast_en_q :
      hit_swi   ? {29'h0000_0000, swi_q} :
      32'h0000_0000;

  // apb handshake, one ack cycle per transfer
  always_comb begin
    unique case (st_q)
      fimvc_pkg::FIMVC_IDLE: st_d = setup ? fimvc_pkg::FIMVC_ACK : fimvc_pkg::FIMVC_IDLE;
      fimvc_pkg::FIMVC_ACK:  st_d = fimvc_pkg::FIMVC_IDLE;
      default:               st_d = fimvc_pkg::FIMVC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= fimvc_pkg::FIMVC_IDLE;
      apb_rsp_q <= '0;
    end else begin
      st_q              <= st_d;
      apb_rsp_q.pready  <= setup;
      apb_rsp_q.prdata  <= setup && !apb_req.pwrite ? rd_data : '0;
      apb_rsp_q.pslverr <= setup && !hit_any;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_en_q <= fimvc_pkg::RST_WORD;
      base_q    <= '0;
      swi_q     <= '0;
    end else begin
      fast_en_q <= fast_en_d;
      if (wr_base) begin
        base_q <= wdata[fimvc_pkg::BASE_W-1:0];
      end
      if (wr_swi) begin
        swi_q <= {wdata[fimvc_pkg::SWI_FIQ_BIT], wdata[fimvc_pkg::SWI_IRQ_BIT], 1'b0};
      end
    end
  end

  // registered views; sources briefer than one cycle may be missed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_raw_q             <= fimvc_pkg::RST_WORD;
      fast_stat_q            <= fimvc_pkg::RST_WORD;
      normal_raw_signal_q    <= fimvc_pkg::RST_WORD;
      normal_masked_status_q <= fimvc_pkg::RST_WORD;
      fast_irq_q             <= 1'b0;
      normal_irq_q           <= 1'b0;
      normal_en_clr_q        <= '0;
    end else begin
      fast_raw_q             <= fraw_d;
      fast_stat_q            <= fstat_d;
      normal_raw_signal_q    <= nraw_d;
      normal_masked_status_q <= nstat_d;
      fast_irq_q             <= fiq_or;
      normal_irq_q           <= nirq_d;
      normal_en_clr_q        <= fen_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_src_q      <= '0;
      fast_vec_src_q <= '0;
      insvc_q        <= '0;
    end else begin
      vec_src_q      <= nest_irq ? n_src : '0;
      fast_vec_src_q <= (nest_fiq && f_found) ? f_src : '0;
      insvc_q        <= insvc_d;
    end
  end

  // checks
  property p_fclr;
    @(posedge clk) disable iff (!rst_b)
      wr_fclr |=> ((fast_en_q & $past(wdata)) == 32'h0000_0000);
  endproperty
  a_fclr: assert property (p_fclr) else $error("fast mask clear left a bit set");

  property p_fstat;
    @(posedge clk) disable iff (!rst_b)
      fast_stat_q[31:2] == ($past(fast_raw_src[31:2]) & $past(fast_en_q[31:2]));
  endproperty
  a_fstat: assert property (p_fstat) else $error("fast status not raw and enable");

  property p_firq;
    @(posedge clk) disable iff (!rst_b)
      (fast_irq_q == |fast_stat_q[31:1]) && (fast_stat_q[0] == fast_irq_q);
  endproperty
  a_firq: assert property (p_firq) else $error("fast request not or of status");

  property p_swi_fiq;
    @(posedge clk) disable iff (!rst_b)
      wr_swi |=> ##1 (fast_stat_q[1] == $past(wdata[2], 2))
                  && (fast_raw_q[1] == fast_stat_q[1]);
  endproperty
  a_swi_fiq: assert property (p_swi_fiq) else $error("programmed fast bit wrong");

  property p_swi_irq;
    @(posedge clk) disable iff (!rst_b)
      wr_swi |=> ##1 (normal_masked_status_q[1] == $past(wdata[1], 2))
                  && (normal_raw_signal_q[1] == normal_masked_status_q[1]);
  endproperty
  a_swi_irq: assert property (p_swi_irq) else $error("programmed normal bit wrong");

  property p_xclr;
    @(posedge clk) disable iff (!rst_b)
      wr_fen |=> normal_en_clr_q == ($past(wdata) & fimvc_pkg::SRC_VALID);
  endproperty
  a_xclr: assert property (p_xclr) else $error("normal mask not cleared");

  property p_novec;
    @(posedge clk) disable iff (!rst_b)
      !nest_irq ##1 !nest_irq |-> (vec_src_q == '0) && (normal_irq_q == |$past(nstat_d));
  endproperty
  a_novec: assert property (p_novec) else $error("plain mode vector nonzero");

  property p_fastwin;
    @(posedge clk) disable iff (!rst_b)
      ($past(nest_irq) && $past(nest_fiq) && fast_irq_q) |-> !normal_irq_q;
  endproperty
  a_fastwin: assert property (p_fastwin) else $error("normal beat fast request");

  property p_vecword;
    @(posedge clk) disable iff (!rst_b)
      (setup && hit_vec && !apb_req.pwrite) |=>
        (apb_rsp_q.prdata == {9'h000, $past(base_q), $past(vec_src_q), 2'b00});
  endproperty
  a_vecword: assert property (p_vecword) else $error("vector word layout wrong");

  property p_baseup;
    @(posedge clk) disable iff (!rst_b)
      (setup && hit_base && !apb_req.pwrite) |=> apb_rsp_q.prdata[31:16] == 16'h0000;
  endproperty
  a_baseup: assert property (p_baseup) else $error("base upper half nonzero");

  property p_nofvec;
    @(posedge clk) disable iff (!rst_b)
      !$past(nest_fiq) |-> fast_vec_src_q == '0;
  endproperty
  a_nofvec: assert property (p_nofvec) else $error("fast vector without vectoring");

  property p_fen_keep;
    @(posedge clk) disable iff (!rst_b)
      (wr_fclr && (normal_en_set == 32'h0000_0000)) |=>
        (fast_en_q == ($past(fast_en_q) & ~$past(wdata)));
  endproperty
  a_fen_keep: assert property (p_fen_keep) else $error("clear hit other bits");

  property p_swi_bypass;
    @(posedge clk) disable iff (!rst_b)
      fast_stat_q[1] == $past(swi_q[fimvc_pkg::SWI_FIQ_BIT]);
  endproperty
  a_swi_bypass: assert property (p_swi_bypass) else $error("programmed bit was masked");

  property p_or_bit;
    @(posedge clk) disable iff (!rst_b)
      (normal_raw_signal_q[0] == fast_irq_q) && (normal_masked_status_q[0] == fast_irq_q)
        && (fast_raw_q[0] == fast_irq_q);
  endproperty
  a_or_bit: assert property (p_or_bit) else $error("or bit differs from fast request");

  property p_en_excl;
    @(posedge clk) disable iff (!rst_b)
      (normal_en_set != 32'h0000_0000) |=>
        ((fast_en_q & $past(normal_en_set)) == 32'h0000_0000);
  endproperty
  a_en_excl: assert property (p_en_excl) else $error("source enabled for both types");

  property p_fen_rsv;
    @(posedge clk) disable iff (!rst_b)
      (fast_en_q & ~fimvc_pkg::SRC_VALID) == 32'h0000_0000;
  endproperty
  a_fen_rsv: assert property (p_fen_rsv) else $error("fast enable outside sources");

  property p_nest_hold;
    @(posedge clk) disable iff (!rst_b)
      ($past(nest_irq) && ({1'b0, $past(n_lvl)} >= $past(cur_lvl))) |-> !normal_irq_q;
  endproperty
  a_nest_hold: assert property (p_nest_hold) else $error("nested request not held");

  property p_pick;
    @(posedge clk) disable iff (!rst_b)
      ($past(nest_irq) && $past(n_found)) |-> (vec_src_q != '0)
        && ((($past(nstat_d) >> vec_src_q) & 32'h0000_0001) == 32'h0000_0001);
  endproperty
  a_pick: assert property (p_pick) else $error("vector names an idle source");

  property p_mark;
    @(posedge clk) disable iff (!rst_b)
      (rd_vec && nest_irq && n_found) |=> (((insvc_q >> $past(n_lvl)) & 8'h01) == 8'h01);
  endproperty
  a_mark: assert property (p_mark) else $error("vector read did not mark level");

  property p_eoi;
    @(posedge clk) disable iff (!rst_b)
      (normal_eoi && !rd_vec && (insvc_q != 8'h00)) |=>
        (($countones(insvc_q) + 1) == $countones($past(insvc_q)));
  endproperty
  a_eoi: assert property (p_eoi) else $error("end of service kept wrong levels");

  property p_fvec;
    @(posedge clk) disable iff (!rst_b)
      ($past(nest_fiq) && $past(f_found)) |-> (fast_vec_src_q != '0)
        && ((($past(fstat_d) >> fast_vec_src_q) & 32'h0000_0001) == 32'h0000_0001);
  endproperty
  a_fvec: assert property (p_fvec) else $error("fast vector names an idle source");

  property p_base;
    @(posedge clk) disable iff (!rst_b)
      wr_base |=> base_q == $past(wdata[fimvc_pkg::BASE_W-1:0]);
  endproperty
  a_base: assert property (p_base) else $error("vector base not stored");

  c_swi_fiq: cover property (@(posedge clk) disable iff (!rst_b) wr_swi && wdata[2]);
  c_vec_rd:  cover property (@(posedge clk) disable iff (!rst_b) rd_vec && nest_irq);
  c_nested:  cover property (@(posedge clk) disable iff (!rst_b) $countones(insvc_q) > 1);
  c_badaddr: cover property (@(posedge clk) disable iff (!rst_b) fire && apb_rsp_q.pslverr);
  c_fastwin: cover property (@(posedge clk) disable iff (!rst_b) nest_fiq && fiq_or && n_found);
endmodule

// [fimvc_src_model.sv]
// peripheral source lines feeding the fast mask and vector block
// assumes the bench asks for levels; the model paces every change
`timescale 1ns/1ps
module fimvc_src_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] fast_want,
  input  wire logic [31:0] norm_want,
  output logic [31:0]      fast_raw_src,
  output logic [31:0]      normal_raw_src
);
  logic [1:0] hold_q;
  // a change stands three edges so the block always sees it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_raw_src   <= 32'h0000_0000;
      normal_raw_src <= 32'h0000_0000;
      hold_q         <= 2'h0;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else if ({fast_raw_src, normal_raw_src} != {fast_want, norm_want}) begin
      fast_raw_src   <= fast_want;
      normal_raw_src <= norm_want;
      hold_q         <= 2'h2;
    end
  end
endmodule

// [testbench.sv]
// self-checking bench for the fast mask and vector block
// assumes an apb slave that answers in its own time and a paced source model
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [31:0] wa, wd, ra, ex;} fimvc_row_s;
  logic                       clk = 1'b0;
  logic                       rst_b = 1'b0;
  fimvc_pkg::fimvc_apb_req_s  req = '0;
  fimvc_pkg::fimvc_apb_rsp_s  rsp;
  logic [31:0]                fw = '0, nw = '0, fsrc, nsrc, nmask = '0, nset = '0;
  logic [31:0]                nraw, nsta, nclr, rd, clr_seen = '0;
  logic [1:0]                 nest = '0;
  fimvc_pkg::fimvc_prio_t     prio = '0;
  logic                       eoi = 1'b0, firq, nirq, er;
  logic [4:0]                 fvec;
  int                         fail_count = 0, tests_run = 0, cyc = 0;
  fimvc_row_s                 rows [9];
  always #20 clk = ~clk;
  // gated so the unknown outputs before the first reset edge never stick
  always @(posedge clk) if (rst_b) clr_seen <= clr_seen | nclr;
  fimvc_src_model src (.clk(clk), .rst_b(rst_b), .fast_want(fw), .norm_want(nw),
    .fast_raw_src(fsrc), .normal_raw_src(nsrc));
  fimvc_top dut (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp_q(rsp),
    .fast_raw_src(fsrc), .normal_raw_src(nsrc), .normal_enable_mask(nmask),
    .normal_en_set(nset), .nesting_control(nest), .prio_fields(prio),
    .normal_eoi(eoi), .fast_irq_q(firq), .normal_irq_q(nirq),
    .normal_raw_signal_q(nraw), .normal_masked_status_q(nsta),
    .normal_en_clr_q(nclr), .fast_vec_src_q(fvec));
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entered just after a rising edge; pready taken at the rising edge itself
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // one idle edge so the next setup never lands on this release
    @(posedge clk);
  endtask
  initial begin
    rows[0] = {fimvc_pkg::ADDR_BASE, 32'hffff_ffff, fimvc_pkg::ADDR_BASE, 32'h0000_ffff};
    rows[1] = {fimvc_pkg::ADDR_FEN, 32'hffff_ffff, fimvc_pkg::ADDR_FEN, 32'h0fff_fffe};
    rows[2] = {fimvc_pkg::ADDR_FCLR, 32'h0000_00f0, fimvc_pkg::ADDR_FEN, 32'h0fff_ff0e};
    rows[3] = {fimvc_pkg::ADDR_FCLR, 32'h0fff_ff0e, fimvc_pkg::ADDR_FEN, 32'h0000_0000};
    rows[4] = {fimvc_pkg::ADDR_SWI, 32'h0000_0004, fimvc_pkg::ADDR_FSTAT, 32'h0000_0003};
    rows[5] = {fimvc_pkg::ADDR_SWI, 32'h0000_0004, fimvc_pkg::ADDR_FRAW, 32'h0000_0003};
    rows[6] = {fimvc_pkg::ADDR_SWI, 32'h0000_0002, fimvc_pkg::ADDR_FSTAT, 32'h0000_0000};
    rows[7] = {fimvc_pkg::ADDR_FSTAT, 32'hffff_ffff, fimvc_pkg::ADDR_SWI, 32'h0000_0002};
    rows[8] = {fimvc_pkg::ADDR_SWI, 32'h0000_0000, fimvc_pkg::ADDR_FRAW, 32'h0000_0000};
    idle(4);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].wa, rows[i].wd);
      idle(2);
      apb(1'b0, rows[i].ra, 32'h0000_0000);
      chk(rd, rows[i].ex);
    end
    chk(clr_seen, 32'h0fff_fffe);
    $display("table done");
    // programmed normal interrupt with the normal mask empty
    apb(1'b1, fimvc_pkg::ADDR_SWI, 32'h0000_0002);
    idle(3);
    chk(nraw, 32'h0000_0002);
    chk(nsta, 32'h0000_0002);
    apb(1'b1, fimvc_pkg::ADDR_SWI, 32'h0000_0000);
    $display("soft normal done");
    // one enabled and one masked fast source
    apb(1'b1, fimvc_pkg::ADDR_FEN, 32'h0000_0020);
    fw <= 32'h0000_0060;
    idle(5);
    apb(1'b0, fimvc_pkg::ADDR_FSTAT, 32'h0000_0000);
    chk(rd, 32'h0000_0021);
    chk({31'h0, firq}, 32'h0000_0001);
    chk({31'h0, nraw[0]}, 32'h0000_0001);
    chk({27'h0, fvec}, 32'h0000_0000);
    nest <= 2'b10;
    idle(2);
    chk({27'h0, fvec}, 32'h0000_0005);
    nest <= 2'b00;
    nset <= 32'h0000_0020;
    @(posedge clk);
    nset <= 32'h0000_0000;
    idle(2);
    apb(1'b0, fimvc_pkg::ADDR_FEN, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, firq}, 32'h0000_0000);
    fw <= 32'h0000_0000;
    $display("fast path done");
    // equal levels tie to the lower source, then a better level wins
    nmask <= 32'h0000_0018;
    nw <= 32'h0000_0018;
    prio[3] <= 3'h2;
    prio[4] <= 3'h2;
    nest <= 2'b01;
    idle(5);
    chk({31'h0, nirq}, 32'h0000_0001);
    // a programmed fast request must hold the normal one down
    nest <= 2'b11;
    apb(1'b1, fimvc_pkg::ADDR_SWI, 32'h0000_0004);
    idle(3);
    chk({31'h0, nirq}, 32'h0000_0000);
    chk({31'h0, firq}, 32'h0000_0001);
    chk({27'h0, fvec}, 32'h0000_0001);
    nest <= 2'b01;
    apb(1'b1, fimvc_pkg::ADDR_SWI, 32'h0000_0000);
    idle(3);
    chk({31'h0, nirq}, 32'h0000_0001);
    apb(1'b0, fimvc_pkg::ADDR_VEC, 32'h0000_0000);
    chk(rd, 32'h007f_ff8c);
    prio[4] <= 3'h1;
    eoi <= 1'b1;
    @(posedge clk);
    eoi <= 1'b0;
    idle(2);
    apb(1'b0, fimvc_pkg::ADDR_VEC, 32'h0000_0000);
    chk(rd, 32'h007f_ff90);
    $display("vector done");
    // unmapped place answers with an error and zero data
    apb(1'b0, 32'hffff_0200, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // second reset in mid-run
    rst_b <= 1'b0;
    idle(4);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, fimvc_pkg::ADDR_BASE, 32'h0000_0000);
    chk(rd, fimvc_pkg::RST_WORD);
    apb(1'b0, fimvc_pkg::ADDR_FEN, 32'h0000_0000);
    chk(rd, fimvc_pkg::RST_WORD);
    $display("reset done");
    close_out();
  end
endmodule
